/* File: common/umbc_pkg.sv */
// Constants, register map and bus carrier for the serial mode and break control block.
// Assumes a 250 MHz core clock and a plain single-cycle register port.
//
// Contract
// - Line control register resets to 16H: LSB first, normal transmit output.
// - Break trigger bit always reads 0; cleared after a correct break field.
// - Break busy reads 1 during break reception, 0 after success or power off.
// - A short break field keeps the busy flag set and re-arms break reception.
// - A same-value line control rewrite is accepted; trigger set starts new break.
// - Line bit 1 picks LSB first when 1; bit 0 inverts transmit output.
// - Line control bits 2 to 5 and 7 are read-only; 0, 1, 6 writable.
// - Capture select 0 routes capture pin, 1 routes serial receive pin.
// - Interrupt select 0 routes its own pin, 1 receive pin; resets 00H.
// - Port 1 direction bit 0 drives the pin, 1 makes it input; resets FFH.
// - Power and both enables 0 means stop mode with plain port pins.
// - Mode register resets to 01H with power and both enables clear.
// - Power bit 0 holds the serial core in asynchronous reset.
// - Power 0 resets error status, transmit status, break flags, receive buffer.
// - Power 0 drives internal transmit high and forces internal receive high.
// - Clearing transmit or receive enable synchronously resets that circuit.
// - Set-up order ends with enables; each transmit buffer write starts sending.
// - Full-duplex operation, every byte preceded by a start bit.

package umbc_pkg;

  // ****************************************************
  // Register byte addresses
  // ****************************************************
  localparam logic [15:0] ADDR_P1_LAT = 16'hff01;
  localparam logic [15:0] ADDR_P1_DIR = 16'hff21;
  localparam logic [15:0] ADDR_MODE = 16'hff50;
  localparam logic [15:0] ADDR_TX_STAT = 16'hff55;
  localparam logic [15:0] ADDR_LINE = 16'hff58;
  localparam logic [15:0] ADDR_ISW = 16'hff59;
  localparam logic [15:0] ADDR_RX_BUF = 16'hff5a;
  localparam logic [15:0] ADDR_TX_BUF = 16'hff5b;
  localparam logic [15:0] ADDR_RX_ERR = 16'hff5c;

  // ****************************************************
  // Reset values and fixed fields
  // ****************************************************
  localparam logic [7:0] RST_P1_DIR = 8'hff;
  localparam logic [7:0] RST_P1_LAT = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h01;
  localparam logic [7:0] RST_LINE = 8'h16;
  localparam logic [1:0] RST_ISW = 2'h0;
  localparam logic [7:0] LINE_FIXED = 8'h14; // Bits 5..2 read 0101

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int MODE_POWER = 7;
  localparam int MODE_TXEN = 6;
  localparam int MODE_RXEN = 5;
  localparam int LINE_BUSY = 7;
  localparam int LINE_TRIG = 6;
  localparam int LINE_DIR = 1;
  localparam int LINE_INV = 0;
  localparam int ISW_CAP = 1;
  localparam int ISW_IRQ = 0;
  localparam int PIN_TX = 3;
  localparam int PIN_RX = 4;
  localparam int ERR_OVR = 0;
  localparam int ERR_FRM = 1;

  // ****************************************************
  // Frame and break timing, in bit periods
  // ****************************************************
  localparam int CHAR_BITS = 8;
  localparam int BRK_BITS = 11;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } umbc_bus_req_t;

endpackage

/* File: src/umbc_tx.sv */
// Transmit buffer and shifter of the serial channel.
// Assumes rst_core already folds in the power bit, and a fixed bit period.

`timescale 1ns/100ps

module umbc_tx #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic core_clk, // Core clock
  input wire logic rst_core, // Async reset, high, includes power off
  input wire logic tx_enable, // Transmit enable
  input wire logic msb_first, // Send most significant bit first
  input wire logic load, // Write pulse to the transmit buffer
  input wire logic [7:0] load_data, // Byte written
  output logic tx_line, // Serial level before inversion
  output logic buf_full, // Buffer holds a byte
  output logic shift_busy // Frame in progress
);

  logic [7:0] buf_data;
  logic [7:0] shift;
  logic [3:0] idx;
  logic [15:0] cnt;

  // Pick one data bit in the chosen order
  function automatic logic umbc_pick(input logic [7:0] d, input logic [3:0] pos,
                                     input logic msb);
    logic [2:0] p;
    p = pos[2:0];
    umbc_pick = msb ? d[3'h7 - p] : d[p];
  endfunction

  // ****************************************************
  // Buffer, shifter and bit timer
  // ****************************************************
  always_ff @(posedge core_clk or posedge rst_core) begin
    if (rst_core) begin
      buf_data <= 8'h00;
      buf_full <= 1'b0;
      shift <= 8'h00;
      idx <= 4'h0;
      cnt <= 16'h0000;
      shift_busy <= 1'b0;
      tx_line <= 1'b1;
    end else if (!tx_enable) begin
      buf_full <= 1'b0;
      shift_busy <= 1'b0;
      idx <= 4'h0;
      cnt <= 16'h0000;
      tx_line <= 1'b1;
    end else begin
      // A write landing in the transfer cycle still marks the buffer full
      if (load) begin
        buf_data <= load_data;
        buf_full <= 1'b1;
      end else if (!shift_busy && buf_full) begin
        buf_full <= 1'b0;
      end
      if (!shift_busy) begin
        if (buf_full) begin
          shift <= buf_data;
          shift_busy <= 1'b1;
          idx <= 4'h0;
          cnt <= 16'(BIT_CYCLES - 1);
          tx_line <= 1'b0;
        end
      end else if (cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end else begin
        cnt <= 16'(BIT_CYCLES - 1);
        idx <= idx + 4'h1;
        if (idx < 4'(umbc_pkg::CHAR_BITS)) begin
          tx_line <= umbc_pick(shift, idx, msb_first);
        end else if (idx == 4'(umbc_pkg::CHAR_BITS)) begin
          tx_line <= 1'b1;
        end else begin
          shift_busy <= 1'b0;
        end
      end
    end
  end

endmodule

/* File: src/umbc_top.sv */
// Mode, line control, break reception, input switching and port 1 pins.
// Assumes a 250 MHz core clock; pins and the routed inputs are asynchronous.
//
// Design decision made here: the plain strobed port.

`timescale 1ns/100ps

module umbc_top #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire umbc_pkg::umbc_bus_req_t bus_req, // Register request
  output logic [7:0] bus_rdata, // Read data, cycle after the strobe
  input wire logic [7:0] p1_in, // Port 1 pin levels
  output logic [7:0] p1_out, // Port 1 output levels
  output logic [7:0] p1_oe, // Port 1 output enables
  input wire logic capture_input_pin, // Dedicated capture pin
  input wire logic ext_irq_pin, // Dedicated interrupt pin
  output logic capture_in, // To the timer capture input
  output logic ext_irq_in // To the external interrupt input
);

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } umbc_rx_st_t;

  // ****************************************************
  // Declarations
  // ****************************************************
  logic [7:0] port1_direction;
  logic [7:0] port1_latch;
  logic [7:0] uart_mode_control;
  logic first_bit_select;
  logic tx_output_invert;
  logic [1:0] input_switch;
  logic [7:0] p1_meta;
  logic [7:0] p1_sync;
  logic cap_meta;
  logic cap_sync;
  logic irq_meta;
  logic irq_sync;
  logic unit_power_on;
  logic tx_enable;
  logic rx_enable;
  logic rst_core;
  logic tx_fn;
  logic rx_fn;
  logic rx_line;
  logic tx_core;
  logic tx_buf_full;
  logic tx_busy;
  logic wr_mode;
  logic wr_line;
  logic wr_isw;
  logic wr_dir;
  logic wr_lat;
  logic wr_txb;
  logic rd_rxb;
  logic rd_err;
  logic brk_go;
  logic break_rx_busy_flag;
  logic [19:0] low_cnt;
  umbc_rx_st_t rx_st;
  logic [15:0] rx_cnt;
  logic [3:0] rx_idx;
  logic [7:0] rx_shift;
  logic rx_done;
  logic rx_frame_bad;
  logic [7:0] rx_buffer;
  logic rx_full;
  logic [1:0] rx_error;
  logic [7:0] next_rdata;

  localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES / 2);
  localparam logic [15:0] FULL_BIT = 16'(BIT_CYCLES - 1);
  localparam logic [19:0] BRK_LOW = 20'(umbc_pkg::BRK_BITS * BIT_CYCLES);

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  // Two stages on every pin; only the second stage is read by logic
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      p1_meta <= 8'hff;
      p1_sync <= 8'hff;
      cap_meta <= 1'b0;
      cap_sync <= 1'b0;
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      p1_meta <= p1_in;
      p1_sync <= p1_meta;
      cap_meta <= capture_input_pin;
      cap_sync <= cap_meta;
      irq_meta <= ext_irq_pin;
      irq_sync <= irq_meta;
    end
  end

  // ****************************************************
  // Mode decode and core reset
  // ****************************************************
  assign unit_power_on = uart_mode_control[umbc_pkg::MODE_POWER];
  assign tx_enable = uart_mode_control[umbc_pkg::MODE_TXEN];
  assign rx_enable = uart_mode_control[umbc_pkg::MODE_RXEN];
  // Power off holds the whole serial core in reset, standing in for a stopped clock
  assign rst_core = rst | ~unit_power_on;
  assign tx_fn = unit_power_on & tx_enable;
  assign rx_fn = unit_power_on & rx_enable;
  // Receive input seen inside is forced high while powered down
  assign rx_line = unit_power_on ? p1_sync[umbc_pkg::PIN_RX] : 1'b1;

  // ****************************************************
  // Register write decode
  // ****************************************************
  assign wr_mode = bus_req.wr && (bus_req.addr == umbc_pkg::ADDR_MODE);
  assign wr_line = bus_req.wr && (bus_req.addr == umbc_pkg::ADDR_LINE);
  assign wr_isw = bus_req.wr && (bus_req.addr == umbc_pkg::ADDR_ISW);
  assign wr_dir = bus_req.wr && (bus_req.addr == umbc_pkg::ADDR_P1_DIR);
  assign wr_lat = bus_req.wr && (bus_req.addr == umbc_pkg::ADDR_P1_LAT);
  assign wr_txb = bus_req.wr && (bus_req.addr == umbc_pkg::ADDR_TX_BUF);
  assign rd_rxb = bus_req.rd && (bus_req.addr == umbc_pkg::ADDR_RX_BUF);
  assign rd_err = bus_req.rd && (bus_req.addr == umbc_pkg::ADDR_RX_ERR);
  // The trigger is never stored, so any write with it set re-arms while power and receive enable are on
  assign brk_go = wr_line && bus_req.wdata[umbc_pkg::LINE_TRIG];

  // ****************************************************
  // Mode register
  // ****************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      uart_mode_control <= umbc_pkg::RST_MODE;
    end else if (wr_mode) begin
      uart_mode_control <= bus_req.wdata;
    end
  end

  // ****************************************************
  // Line control: only order and inversion are stored
  // ****************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      first_bit_select <= umbc_pkg::RST_LINE[umbc_pkg::LINE_DIR];
      tx_output_invert <= umbc_pkg::RST_LINE[umbc_pkg::LINE_INV];
    end else if (wr_line) begin
      // Changes mid-frame are not guarded; software idles both enables first
      first_bit_select <= bus_req.wdata[umbc_pkg::LINE_DIR];
      tx_output_invert <= bus_req.wdata[umbc_pkg::LINE_INV];
    end
  end

  // ****************************************************
  // Input switch register
  // ****************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      input_switch <= umbc_pkg::RST_ISW;
    end else if (wr_isw) begin
      input_switch <= {bus_req.wdata[umbc_pkg::ISW_CAP], bus_req.wdata[umbc_pkg::ISW_IRQ]};
    end
  end

  // ****************************************************
  // Port 1 direction and latch
  // ****************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port1_direction <= umbc_pkg::RST_P1_DIR;
    end else if (wr_dir) begin
      port1_direction <= bus_req.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port1_latch <= umbc_pkg::RST_P1_LAT;
    end else if (wr_lat) begin
      port1_latch <= bus_req.wdata;
    end
  end

  // ****************************************************
  // Routed inputs to the timer and interrupt logic
  // ****************************************************
  // Routing uses the synchronised receive pin, not rx_line, so it works with the channel stopped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      capture_in <= 1'b0;
      ext_irq_in <= 1'b0;
    end else begin
      capture_in <= input_switch[1] ? p1_sync[umbc_pkg::PIN_RX] : cap_sync;
      ext_irq_in <= input_switch[0] ? p1_sync[umbc_pkg::PIN_RX] : irq_sync;
    end
  end

  // ****************************************************
  // Port 1 pin drivers
  // ****************************************************
  // Direction bit low turns the output buffer on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      p1_out <= umbc_pkg::RST_P1_LAT;
      p1_oe <= ~umbc_pkg::RST_P1_DIR;
    end else begin
      p1_oe <= ~port1_direction;
      p1_out <= port1_latch;
      if (tx_fn) begin
        p1_out[umbc_pkg::PIN_TX] <= tx_core ^ tx_output_invert;
      end
    end
  end

  // ****************************************************
  // Transmitter
  // ****************************************************
  umbc_tx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_tx (
    .core_clk(core_clk),
    .rst_core(rst_core),
    .tx_enable(tx_enable),
    .msb_first(~first_bit_select),
    .load(wr_txb && tx_fn),
    .load_data(bus_req.wdata),
    .tx_line(tx_core),
    .buf_full(tx_buf_full),
    .shift_busy(tx_busy)
  );

  // ****************************************************
  // Break field reception
  // ****************************************************
  // Measures one low stretch; its rising edge decides success or retry
  always_ff @(posedge core_clk or posedge rst_core) begin
    if (rst_core) begin
      break_rx_busy_flag <= 1'b0;
      low_cnt <= 20'h00000;
    end else if (brk_go && rx_fn) begin
      break_rx_busy_flag <= 1'b1;
      low_cnt <= 20'h00000;
    end else if (break_rx_busy_flag) begin
      if (!rx_line) begin
        if (low_cnt != 20'hfffff) begin
          low_cnt <= low_cnt + 20'h00001;
        end
      end else if (low_cnt != 20'h00000) begin
        low_cnt <= 20'h00000;
        if (low_cnt >= BRK_LOW) begin
          break_rx_busy_flag <= 1'b0;
        end
        // A short low stretch leaves the flag set and waits again
      end
    end
  end

  // ****************************************************
  // Receiver
  // ****************************************************
  // Samples mid-bit; held idle while a break field is awaited
  always_ff @(posedge core_clk or posedge rst_core) begin
    if (rst_core) begin
      rx_st <= RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_idx <= 4'h0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
      rx_frame_bad <= 1'b0;
    end else if (!rx_enable || break_rx_busy_flag) begin
      rx_st <= RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_idx <= 4'h0;
      rx_done <= 1'b0;
      rx_frame_bad <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_st)
        RX_IDLE: begin
          if (!rx_line) begin
            rx_st <= RX_START;
            rx_cnt <= HALF_BIT;
          end
        end
        RX_START: begin
          if (rx_cnt != 16'h0000) begin
            rx_cnt <= rx_cnt - 16'h0001;
          end else if (!rx_line) begin
            rx_st <= RX_DATA;
            rx_cnt <= FULL_BIT;
            rx_idx <= 4'h0;
          end else begin
            rx_st <= RX_IDLE;
          end
        end
        RX_DATA: begin
          if (rx_cnt != 16'h0000) begin
            rx_cnt <= rx_cnt - 16'h0001;
          end else begin
            rx_cnt <= FULL_BIT;
            rx_idx <= rx_idx + 4'h1;
            if (first_bit_select) begin
              rx_shift <= {rx_line, rx_shift[7:1]};
            end else begin
              rx_shift <= {rx_shift[6:0], rx_line};
            end
            if (rx_idx == 4'(umbc_pkg::CHAR_BITS - 1)) begin
              rx_st <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_cnt != 16'h0000) begin
            rx_cnt <= rx_cnt - 16'h0001;
          end else begin
            rx_st <= RX_IDLE;
            rx_done <= 1'b1;
            rx_frame_bad <= ~rx_line;
          end
        end
        default: begin
          rx_st <= RX_IDLE;
        end
      endcase
    end
  end

  // ****************************************************
  // Receive buffer and error status
  // ****************************************************
  // A new byte in the cycle of a buffer read keeps the full flag set
  always_ff @(posedge core_clk or posedge rst_core) begin
    if (rst_core) begin
      rx_buffer <= 8'h00;
      rx_full <= 1'b0;
    end else if (rx_done) begin
      rx_buffer <= rx_shift;
      rx_full <= 1'b1;
    end else if (rd_rxb) begin
      rx_full <= 1'b0;
    end
  end

  // Errors are sticky until read; a new error wins over the read clear
  always_ff @(posedge core_clk or posedge rst_core) begin
    if (rst_core) begin
      rx_error <= 2'h0;
    end else begin
      rx_error[umbc_pkg::ERR_OVR] <= (rx_done && rx_full && !rd_rxb)
                                    || (rx_error[umbc_pkg::ERR_OVR] && !rd_err);
      rx_error[umbc_pkg::ERR_FRM] <= (rx_done && rx_frame_bad)
                                    || (rx_error[umbc_pkg::ERR_FRM] && !rd_err);
    end
  end

  // ****************************************************
  // Read path
  // ****************************************************
  always_comb begin
    next_rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        umbc_pkg::ADDR_MODE: next_rdata = uart_mode_control;
        umbc_pkg::ADDR_LINE: begin
          // Trigger reads 0 and fixed bits read back their constant
          next_rdata = umbc_pkg::LINE_FIXED;
          next_rdata[umbc_pkg::LINE_BUSY] = break_rx_busy_flag;
          next_rdata[umbc_pkg::LINE_DIR] = first_bit_select;
          next_rdata[umbc_pkg::LINE_INV] = tx_output_invert;
        end
        umbc_pkg::ADDR_ISW: next_rdata = {6'h00, input_switch};
        umbc_pkg::ADDR_P1_DIR: next_rdata = port1_direction;
        umbc_pkg::ADDR_P1_LAT: next_rdata = port1_latch;
        umbc_pkg::ADDR_TX_STAT: next_rdata = {6'h00, tx_buf_full, tx_busy};
        umbc_pkg::ADDR_RX_BUF: next_rdata = rx_buffer;
        umbc_pkg::ADDR_RX_ERR: next_rdata = {6'h00, rx_error};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

endmodule

/* File: tb/umbc_properties.sv */
// Checker for the serial mode block, bound to umbc_top.
// Assumes only the top ports; keeps shadows of the registers it needs.
`timescale 1ns/100ps
module umbc_properties (
  input wire logic core_clk, // Clock
  input wire logic rst, // Async reset
  input wire umbc_pkg::umbc_bus_req_t bus_req, // Register request
  input wire logic [7:0] bus_rdata, // Read data
  input wire logic [7:0] p1_in, // Pin levels
  input wire logic [7:0] p1_out, // Pin outputs
  input wire logic [7:0] p1_oe, // Pin enables
  input wire logic capture_input_pin, // Capture pin
  input wire logic ext_irq_pin, // Interrupt pin
  input wire logic capture_in, // Routed capture
  input wire logic ext_irq_in // Routed interrupt
);
  logic [7:0] mode_sh; // Mode shadow
  logic [7:0] lat_sh; // Latch shadow
  logic [1:0] isw_sh; // Switch shadow
  localparam logic [15:0] LN = umbc_pkg::ADDR_LINE;
  logic w, r;
  logic [15:0] a;
  assign w = bus_req.wr;
  assign r = bus_req.rd;
  assign a = bus_req.addr;
  // Shadows take writes as the design does
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_sh <= umbc_pkg::RST_MODE;
      lat_sh <= umbc_pkg::RST_P1_LAT;
      isw_sh <= umbc_pkg::RST_ISW;
    end else if (w) begin
      if (a == umbc_pkg::ADDR_MODE) mode_sh <= bus_req.wdata;
      if (a == umbc_pkg::ADDR_P1_LAT) lat_sh <= bus_req.wdata;
      if (a == umbc_pkg::ADDR_ISW) isw_sh <= bus_req.wdata[1:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************************************************
  // Properties
  // ****************************************************
  property p_line_fix; r && a == LN |=> bus_rdata[6:2] == 5'h05; endproperty
  a_line_fix: assert property (p_line_fix) else $error("line fixed bits");
  property p_busy_set;
    w && a == LN && bus_req.wdata[6] && mode_sh[7] && mode_sh[5]
      ##2 r && a == LN |=> bus_rdata[7];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set");
  property p_off_busy; r && a == LN && !mode_sh[7] |=> !bus_rdata[7]; endproperty
  a_off_busy: assert property (p_off_busy) else $error("busy with power off");
  property p_mode_rd; r && a == umbc_pkg::ADDR_MODE |=> bus_rdata == mode_sh; endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback");
  property p_isw_rd; r && a == umbc_pkg::ADDR_ISW |=> bus_rdata == {6'h00, isw_sh}; endproperty
  a_isw_rd: assert property (p_isw_rd) else $error("switch readback");
  property p_oe;
    w && a == umbc_pkg::ADDR_P1_DIR |-> ##2 p1_oe == ~$past(bus_req.wdata, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable");
  property p_cap;
    ($stable(isw_sh) && $stable(p1_in[4]) && $stable(capture_input_pin))[*5]
      |-> capture_in == (isw_sh[1] ? p1_in[4] : capture_input_pin);
  endproperty
  a_cap: assert property (p_cap) else $error("capture route");
  property p_irq;
    ($stable(isw_sh) && $stable(p1_in[4]) && $stable(ext_irq_pin))[*5]
      |-> ext_irq_in == (isw_sh[0] ? p1_in[4] : ext_irq_pin);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt route");
  property p_tx_port;
    (!(mode_sh[7] && mode_sh[6]) && $stable(lat_sh))[*3] |-> p1_out[3] == lat_sh[3];
  endproperty
  a_tx_port: assert property (p_tx_port) else $error("tx pin not port");
endmodule
bind umbc_top umbc_properties u_umbc_properties (.*);

/* File: tb/umbc_node.sv */
// Remote serial node on the port 1 serial pins.
// Assumes 8N1 frames and a bit period of BIT_CYCLES core cycles.
`timescale 1ns/100ps
module umbc_node #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic core_clk, // Clock
  input wire logic tx_pin, // Device transmit pin level
  output logic rx_pin // Level we put on the receive pin
);
  // Line idles high between frames
  initial rx_pin = 1'b1;
  // Start low, eight bits, stop high
  task automatic send_frame(input logic [7:0] d, input logic lsb);
    for (int i = 0; i < 10; i++) begin
      rx_pin <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : d[lsb ? i - 1 : 8 - i];
      repeat (BIT_CYCLES) @(posedge core_clk);
    end
  endtask
  // Low stretch of n bit periods, then idle
  task automatic send_break(input int n);
    rx_pin <= 1'b0;
    repeat (n * BIT_CYCLES) @(posedge core_clk);
    rx_pin <= 1'b1;
    repeat (BIT_CYCLES) @(posedge core_clk);
  endtask
  // Bounded wait for a start bit, then mid-bit samples
  task automatic get_frame(output logic [7:0] d, input logic lsb, input logic inv,
                           output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int n = 0; n < 400 && !ok; n++) begin
      @(posedge core_clk);
      ok = (tx_pin ^ inv) == 1'b0;
    end
    repeat (BIT_CYCLES / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge core_clk);
      s[lsb ? i : 7 - i] = tx_pin ^ inv;
    end
    d = s;
  endtask
endmodule

/* File: tb/umbc_bench.sv */
// Self-checking bench for the serial mode and break control block.
// Assumes the remote node model and the bound checker.
`timescale 1ns/100ps
module umbc_bench;
  localparam int BC = 4;
  localparam logic [15:0] MD = umbc_pkg::ADDR_MODE, LN = umbc_pkg::ADDR_LINE;
  localparam logic [15:0] SW = umbc_pkg::ADDR_ISW, DR = umbc_pkg::ADDR_P1_DIR;
  logic core_clk, rst, capture_input_pin, ext_irq_pin, capture_in, ext_irq_in, node_rx;
  umbc_pkg::umbc_bus_req_t bus_req;
  logic [7:0] bus_rdata, p1_out, p1_oe, p1_in;
  int bad_count, cmp_count;
  // Pins: driven bits, else node on bit 4, pull-ups elsewhere
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & {3'h7, node_rx, 4'hf});
  umbc_top #(.BIT_CYCLES(BC)) u_umbc_top (.*);
  umbc_node #(.BIT_CYCLES(BC)) u_umbc_node (.core_clk(core_clk), .tx_pin(p1_out[3]),
    .rx_pin(node_rx));
  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bus cycles start after an edge; one idle edge follows
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
  endtask
  task automatic rdck(input logic [15:0] a, input logic [7:0] exp, input string what);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1 check(what, bus_rdata, exp);
    @(posedge core_clk);
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One byte each way; rx byte read after its stop bit
  task automatic duplex(input logic [7:0] t, input logic [7:0] r, input logic lsb,
                        input logic inv);
    logic [7:0] q;
    logic ok;
    fork
      wr(umbc_pkg::ADDR_TX_BUF, t);
      u_umbc_node.send_frame(r, lsb);
      u_umbc_node.get_frame(q, lsb, inv, ok);
    join
    check("tx start", {7'h00, ok}, 8'h01);
    check("tx byte", q, t);
    repeat (BC) @(posedge core_clk);
    rdck(umbc_pkg::ADDR_RX_BUF, r, "rx byte");
  endtask
  // Rows: write flag, address, write data, expected read
  logic [32:0] rows [9] = '{
    {1'b0, DR, 8'h00, 8'hff}, {1'b0, MD, 8'h00, 8'h01}, {1'b0, LN, 8'h00, 8'h16},
    {1'b0, SW, 8'h00, 8'h00}, {1'b1, LN, 8'hff, 8'h17}, {1'b1, LN, 8'h00, 8'h14},
    {1'b1, SW, 8'h03, 8'h03}, {1'b1, SW, 8'h00, 8'h00}, {1'b0, 16'hff00, 8'h00, 8'h00}};
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    rst = 1'b1;
    bus_req = '0;
    capture_input_pin = 1'b0;
    ext_irq_pin = 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      if (rows[i][32]) wr(rows[i][31:16], rows[i][15:8]);
      rdck(rows[i][31:16], rows[i][7:0], "row");
    end
    $display("test rows done");
    // Pins set for serial use, power before enables, LSB first
    wr(umbc_pkg::ADDR_P1_LAT, 8'h08);
    wr(DR, 8'hf7);
    wr(LN, 8'h16);
    wr(MD, 8'h81);
    wr(MD, 8'he1);
    duplex(8'ha3, 8'h5c, 1'b1, 1'b0);
    // Enables off before order and inversion change; MSB first, inverted
    wr(MD, 8'h81);
    wr(LN, 8'h15);
    rdck(LN, 8'h15, "line");
    wr(MD, 8'he1);
    duplex(8'h3a, 8'hc6, 1'b0, 1'b1);
    $display("test duplex done");
    // Break: short field keeps busy, long one clears it, rewrite re-arms
    wr(MD, 8'h81);
    wr(LN, 8'h16);
    wr(MD, 8'he1);
    wr(LN, 8'h56);
    rdck(LN, 8'h96, "busy");
    u_umbc_node.send_break(5);
    rdck(LN, 8'h96, "short break");
    u_umbc_node.send_break(12);
    rdck(LN, 8'h16, "break done");
    wr(LN, 8'h56);
    rdck(LN, 8'h96, "rearm");
    wr(MD, 8'h81);
    wr(MD, 8'h01);
    rdck(LN, 8'h16, "power off");
    $display("test break done");
    // Every switch setting, pins low and receive line idle high
    for (int s = 0; s < 4; s++) begin
      wr(SW, 8'(s));
      repeat (6) @(posedge core_clk);
      check("capture", {7'h00, capture_in}, {7'h00, s[1]});
      check("irq", {7'h00, ext_irq_in}, {7'h00, s[0]});
    end
    $display("test switch done");
    print_verdict();
  end
endmodule
